// ==== shared/thv_params.svh ====
// constants of the trig and hyperbolic vector/rotate unit
`ifndef THV_PARAMS_SVH
`define THV_PARAMS_SVH
// opcode of the unit, octal 37, register_to_register_format only
`define THV_OPCODE 6'h1f
// general register count and operand width
`define THV_REGS 16
`define THV_WORD_W 16
// function field bit positions
`define THV_FN_ROT 0
`define THV_FN_SCALE 1
`define THV_FN_HYP 2
// internal datapath: two guard bits above, two below
`define THV_ACC_W 20
`define THV_GUARD 2
// iteration schedule (shift amounts)
`define THV_TRIG_LAST 5'h0f
`define THV_HYP_FIRST 5'h01
`define THV_HYP_LAST 5'h0f
`define THV_HYP_REP_A 5'h04
`define THV_HYP_REP_B 5'h0d
// gain constants: octal 0.46672 (q15) and octal 1.15217 (q14)
`define THV_K_TRIG 16'h4dba
`define THV_K_TRIG_FRAC 15
`define THV_K_HYP 16'h4d48
`define THV_K_HYP_FRAC 14
// binary_angle_format landmarks
`define THV_ANG_90 17'h04000
`define THV_ANG_180 16'h8000
// operand limits checked by the decoder end
`define THV_POS_MAX 16'h2000
`define THV_HYP_ANG_MAX 16'h2000
`endif

// ==== shared/thv_pkg.sv ====
// types shared by both ends of the trig/hyperbolic unit
`include "thv_params.svh"
package thv_pkg;
    typedef logic [`THV_WORD_W-1:0] thv_word_t;
    typedef logic signed [`THV_ACC_W-1:0] thv_acc_t;
    typedef logic signed [`THV_WORD_W:0] thv_ang_t;
    typedef enum logic [1:0] {thv_st_idle, thv_st_pre, thv_st_iter, thv_st_scale} thv_state_t;
endpackage

// ==== shared/thv_if.sv ====
// link between instruction decoder/register file and the unit
`timescale 1ns/1ps
`default_nettype none
interface thv_if;
    logic issue;
    logic [5:0] opcode;
    logic rr_form;
    logic [3:0] base;
    logic [2:0] func;
    thv_pkg::thv_word_t op_y;
    thv_pkg::thv_word_t op_x;
    thv_pkg::thv_word_t op_w;
    logic busy;
    logic wb_en;
    logic [3:0] wb_base;
    thv_pkg::thv_word_t wb_y;
    thv_pkg::thv_word_t wb_x;
    thv_pkg::thv_word_t wb_w;
    modport unit (input issue, opcode, rr_form, base, func, op_y, op_x, op_w,
                  output busy, wb_en, wb_base, wb_y, wb_x, wb_w);
    modport decoder (output issue, opcode, rr_form, base, func, op_y, op_x, op_w,
                     input busy, wb_en, wb_base, wb_y, wb_x, wb_w);
endinterface
`default_nettype wire

// ==== core/thv_cordic_unit.sv ====
// shift-and-add trig/hyperbolic vector and rotate unit
`timescale 1ns/1ps
`default_nettype none
`include "thv_params.svh"
// Function
// RULE1 - runs only for register_to_register_format opcode 37
// RULE2 - operands are registers base, base+1, base+2
// RULE3 - base is y, base+1 x, base+2 angle
// RULE4 - y and x binary point below bit 15
// RULE5 - hyperbolic angle binary point below bit 14
// RULE6 - coordinates are 16-bit two's complement
// RULE7 - software prescales coordinates against overflow
// RULE8 - angle in binary_angle_format, bit 15 is 180
// RULE9 - angle lsb weighs 90 over 2^14 degrees
// RULE10 - angle may be read as signed two's complement
// RULE11 - negative x, zero y gives angle 0x8000
// RULE12 - positive angle rotates counterclockwise, negative clockwise
// RULE13 - software keeps abs(y/x) below one
// RULE14 - hyperbolic angle is 16-bit two's complement
// RULE15 - software keeps e to the angle in range
// RULE16 - hyperbolic vector angle sign follows y>0
// RULE17 - software keeps positive hyperbolic coordinates <= 0.25
// RULE18 - opposite hyperbolic rotations are mutual inverses
// RULE19 - function field selects one of eight functions
// RULE20 - unscaled results keep gain; clear y or w
// RULE21 - iterate, stall pipeline, write three results together
module thv_cordic_unit #(
    parameter int WORD_W = `THV_WORD_W
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    thv_if.unit ifc
);
    // ****************************************
    // parameter check
    // ****************************************
    generate
        if (WORD_W != 16) begin : g_bad_width
            $error("thv_cordic_unit: angle tables need a 16-bit word");
        end
    endgenerate

    // ****************************************
    // lookup tables
    // ****************************************
    // arctan(2^-i) in binary_angle_format units
    function automatic logic [15:0] atan_tab(input logic [4:0] sh);
        case (sh)
            5'h00: atan_tab = 16'h2000;
            5'h01: atan_tab = 16'h12e4;
            5'h02: atan_tab = 16'h09fb;
            5'h03: atan_tab = 16'h0511;
            5'h04: atan_tab = 16'h028b;
            5'h05: atan_tab = 16'h0146;
            5'h06: atan_tab = 16'h00a3;
            5'h07: atan_tab = 16'h0051;
            5'h08: atan_tab = 16'h0029;
            5'h09: atan_tab = 16'h0014;
            5'h0a: atan_tab = 16'h000a;
            5'h0b: atan_tab = 16'h0005;
            5'h0c: atan_tab = 16'h0003;
            5'h0d: atan_tab = 16'h0001;
            5'h0e: atan_tab = 16'h0001;
            default: atan_tab = 16'h0000;
        endcase
    endfunction

    // artanh(2^-i) with binary point below bit 14, same scale as w
    function automatic logic [15:0] atanh_tab(input logic [4:0] sh);
        case (sh)
            5'h01: atanh_tab = 16'h2328; // [RULE5]
            5'h02: atanh_tab = 16'h1059;
            5'h03: atanh_tab = 16'h080b;
            5'h04: atanh_tab = 16'h0401;
            5'h05: atanh_tab = 16'h0200;
            5'h06: atanh_tab = 16'h0100;
            5'h07: atanh_tab = 16'h0080;
            5'h08: atanh_tab = 16'h0040;
            5'h09: atanh_tab = 16'h0020;
            5'h0a: atanh_tab = 16'h0010;
            5'h0b: atanh_tab = 16'h0008;
            5'h0c: atanh_tab = 16'h0004;
            5'h0d: atanh_tab = 16'h0002;
            5'h0e: atanh_tab = 16'h0001;
            default: atanh_tab = 16'h0000;
        endcase
    endfunction

    // word to accumulator, sign extended with low guard bits
    function automatic thv_pkg::thv_acc_t widen(input thv_pkg::thv_word_t v);
        widen = {{`THV_GUARD{v[15]}}, v, {`THV_GUARD{1'b0}}};
    endfunction

    // ****************************************
    // state
    // ****************************************
    thv_pkg::thv_state_t state_q;
    logic [2:0] fn_q;
    logic [3:0] base_q;
    thv_pkg::thv_acc_t x_q;
    thv_pkg::thv_acc_t y_q;
    thv_pkg::thv_ang_t z_q;
    logic [4:0] sh_q;
    logic rep_q;
    logic neg180_q;
    logic wb_en_q;
    logic [3:0] wb_base_q;
    thv_pkg::thv_word_t wb_y_q;
    thv_pkg::thv_word_t wb_x_q;
    thv_pkg::thv_word_t wb_w_q;

    logic accept;
    logic is_hyp;
    logic is_rot;
    logic d_pos;
    logic last_step;
    logic rep_step;
    thv_pkg::thv_acc_t xs;
    thv_pkg::thv_acc_t ys;
    thv_pkg::thv_ang_t e;
    logic signed [36:0] px;
    logic signed [36:0] py;
    thv_pkg::thv_acc_t fx;
    thv_pkg::thv_acc_t fy;

    // ****************************************
    // decode and step control
    // ****************************************
    assign accept = ifc.issue && ifc.opcode == `THV_OPCODE && ifc.rr_form
                    && state_q == thv_pkg::thv_st_idle; // [RULE1]
    assign is_hyp = fn_q[`THV_FN_HYP]; // [RULE19]
    assign is_rot = fn_q[`THV_FN_ROT];
    // rotate follows the angle sign, vector drives y toward zero
    assign d_pos = is_rot ? !z_q[16] : (y_q <= 0); // [RULE12] [RULE16] [RULE18]
    assign xs = x_q >>> sh_q;
    assign ys = y_q >>> sh_q;
    assign e = {1'b0, is_hyp ? atanh_tab(sh_q) : atan_tab(sh_q)}; // [RULE9]
    assign rep_step = is_hyp && !rep_q && (sh_q == `THV_HYP_REP_A || sh_q == `THV_HYP_REP_B);
    assign last_step = !rep_step && sh_q == (is_hyp ? `THV_HYP_LAST : `THV_TRIG_LAST);
    assign ifc.busy = state_q != thv_pkg::thv_st_idle; // [RULE21]

    // sequencer
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state_q <= thv_pkg::thv_st_idle;
            sh_q <= 5'h00;
            rep_q <= 1'b0;
        end else begin
            unique case (state_q)
                thv_pkg::thv_st_idle: begin
                    if (accept) begin
                        state_q <= thv_pkg::thv_st_pre;
                    end
                end
                thv_pkg::thv_st_pre: begin
                    state_q <= thv_pkg::thv_st_iter;
                    sh_q <= is_hyp ? `THV_HYP_FIRST : 5'h00;
                    rep_q <= 1'b0;
                end
                thv_pkg::thv_st_iter: begin
                    rep_q <= rep_step; // hyperbolic repeats keep convergence
                    if (!rep_step) begin
                        sh_q <= sh_q + 5'h01;
                    end
                    if (last_step) begin
                        state_q <= thv_pkg::thv_st_scale; // [RULE21]
                    end
                end
                thv_pkg::thv_st_scale: begin
                    state_q <= thv_pkg::thv_st_idle;
                end
            endcase
        end
    end

    // ****************************************
    // datapath
    // ****************************************
    // load, quadrant fold, micro-rotations
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            fn_q <= 3'h0;
            base_q <= 4'h0;
            x_q <= '0;
            y_q <= '0;
            z_q <= '0;
            neg180_q <= 1'b0;
        end else if (accept) begin
            fn_q <= ifc.func; // [RULE19]
            base_q <= ifc.base; // [RULE2]
            y_q <= widen(ifc.op_y); // [RULE3] [RULE4] [RULE6]
            x_q <= widen(ifc.op_x);
            z_q <= {ifc.op_w[15], ifc.op_w}; // [RULE5] [RULE8] [RULE10] [RULE14]
            neg180_q <= 1'b0;
        end else if (state_q == thv_pkg::thv_st_pre && !is_hyp) begin
            // fold into the +-90 degree range the iterations cover
            if (!is_rot && x_q < 0) begin
                neg180_q <= (y_q == 0); // [RULE11]
                if (y_q > 0) begin
                    x_q <= y_q;
                    y_q <= -x_q;
                    z_q <= z_q + $signed(`THV_ANG_90);
                end else begin
                    x_q <= -y_q;
                    y_q <= x_q;
                    z_q <= z_q - $signed(`THV_ANG_90);
                end
            end else if (is_rot && z_q[15:14] == 2'b01) begin
                x_q <= -y_q; // +90 counterclockwise
                y_q <= x_q;
                z_q <= z_q - $signed(`THV_ANG_90); // [RULE12]
            end else if (is_rot && z_q[15:14] == 2'b10) begin
                x_q <= y_q; // -90 clockwise
                y_q <= -x_q;
                z_q <= z_q + $signed(`THV_ANG_90);
            end
        end else if (state_q == thv_pkg::thv_st_iter) begin
            // trig: x -= d*y>>i ; hyperbolic: x += d*y>>i
            if (d_pos ^ is_hyp) begin
                x_q <= x_q - ys;
            end else begin
                x_q <= x_q + ys;
            end
            y_q <= d_pos ? y_q + xs : y_q - xs;
            z_q <= d_pos ? z_q - e : z_q + e; // [RULE16] [RULE18]
        end
    end

    // ****************************************
    // scaling and write-back
    // ****************************************
    // gain correction multiply for the scaled variants
    assign px = x_q * $signed({1'b0, is_hyp ? `THV_K_HYP : `THV_K_TRIG});
    assign py = y_q * $signed({1'b0, is_hyp ? `THV_K_HYP : `THV_K_TRIG});
    always_comb begin
        if (!fn_q[`THV_FN_SCALE]) begin
            fx = x_q; // [RULE20]
            fy = y_q;
        end else if (is_hyp) begin
            fx = px[`THV_K_HYP_FRAC +: `THV_ACC_W];
            fy = py[`THV_K_HYP_FRAC +: `THV_ACC_W];
        end else begin
            fx = px[`THV_K_TRIG_FRAC +: `THV_ACC_W];
            fy = py[`THV_K_TRIG_FRAC +: `THV_ACC_W];
        end
    end

    // all three results leave in one pulse
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            wb_en_q <= 1'b0;
            wb_base_q <= 4'h0;
            wb_y_q <= '0;
            wb_x_q <= '0;
            wb_w_q <= '0;
        end else begin
            wb_en_q <= state_q == thv_pkg::thv_st_scale; // [RULE21]
            if (state_q == thv_pkg::thv_st_scale) begin
                wb_base_q <= base_q; // [RULE2]
                wb_x_q <= fx[`THV_GUARD +: 16];
                wb_y_q <= is_rot ? fy[`THV_GUARD +: 16] : 16'h0000; // [RULE20]
                if (is_rot) begin
                    wb_w_q <= 16'h0000; // [RULE20]
                end else if (neg180_q) begin
                    wb_w_q <= `THV_ANG_180; // [RULE11]
                end else begin
                    wb_w_q <= z_q[15:0];
                end
            end
        end
    end

    assign ifc.wb_en = wb_en_q;
    assign ifc.wb_base = wb_base_q;
    assign ifc.wb_y = wb_y_q;
    assign ifc.wb_x = wb_x_q;
    assign ifc.wb_w = wb_w_q;
endmodule
`default_nettype wire

// ==== core/thv_decode_end.sv ====
// decoder and general register file end of the unit link
`timescale 1ns/1ps
`default_nettype none
`include "thv_params.svh"
module thv_decode_end #(
    parameter int REGS = `THV_REGS
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    thv_if.decoder ifc,
    input wire logic i_issue,
    input wire logic [5:0] i_opcode,
    input wire logic i_rr_form,
    input wire logic [3:0] i_base,
    input wire logic [2:0] i_func,
    output logic o_stall,
    output logic o_done,
    output logic o_refused,
    output logic o_range_warn,
    input wire logic i_reg_we,
    input wire logic [3:0] i_reg_idx,
    input wire logic [15:0] i_reg_wdata,
    input wire logic i_reg_re,
    output logic [15:0] o_reg_rdata
);
    // ****************************************
    // parameter check
    // ****************************************
    generate
        if (REGS != 16) begin : g_bad_regs
            $error("thv_decode_end: register index is four bits");
        end
    endgenerate

    function automatic logic [15:0] mag(input logic [15:0] v);
        mag = v[15] ? 16'h0000 - v : v;
    endfunction

    logic [15:0] rf_q [REGS];
    logic pend_q;
    logic issue_q;
    logic refused_q;
    logic warn_q;
    logic done_q;
    logic [15:0] rdata_q;
    logic [5:0] opcode_q;
    logic [3:0] base_q;
    logic [2:0] func_q;
    logic [15:0] y_q;
    logic [15:0] x_q;
    logic [15:0] w_q;
    logic launch;
    logic legal;
    logic [15:0] ny;
    logic [15:0] nx;
    logic [15:0] nw;

    // ****************************************
    // launch
    // ****************************************
    assign legal = i_opcode == `THV_OPCODE && i_rr_form; // [RULE1]
    assign launch = i_issue && !pend_q && legal;
    assign ny = rf_q[i_base]; // [RULE2] [RULE3]
    assign nx = rf_q[i_base + 4'h1];
    assign nw = rf_q[i_base + 4'h2];

    // request, hold until write-back
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            pend_q <= 1'b0;
            issue_q <= 1'b0;
            refused_q <= 1'b0;
        end else begin
            issue_q <= launch;
            refused_q <= i_issue && !pend_q && !legal;
            if (launch) begin
                pend_q <= 1'b1;
            end else if (ifc.wb_en) begin
                pend_q <= 1'b0; // [RULE21]
            end
        end
    end

    // operand latch
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            opcode_q <= 6'h00;
            base_q <= 4'h0;
            func_q <= 3'h0;
            y_q <= 16'h0000;
            x_q <= 16'h0000;
            w_q <= 16'h0000;
        end else if (launch) begin
            opcode_q <= i_opcode;
            base_q <= i_base;
            func_q <= i_func; // [RULE19]
            y_q <= ny;
            x_q <= nx;
            w_q <= nw;
        end
    end

    // operand range screen for software scaling duties
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            warn_q <= 1'b0;
        end else if (launch) begin
            if (!i_func[`THV_FN_HYP]) begin
                warn_q <= 1'b0; // [RULE7]
            end else if (!i_func[`THV_FN_ROT]) begin
                warn_q <= mag(ny) >= mag(nx) // [RULE13]
                          || (!ny[15] && ny > `THV_POS_MAX)
                          || (!nx[15] && nx > `THV_POS_MAX); // [RULE17]
            end else begin
                warn_q <= mag(nw) > `THV_HYP_ANG_MAX; // [RULE15]
            end
        end
    end

    // ****************************************
    // register file
    // ****************************************
    generate
        for (genvar r = 0; r < REGS; r++) begin : g_rf
            // write-back of all three results beats a software write
            always_ff @(posedge i_mclk) begin
                if (i_rst) begin
                    rf_q[r] <= 16'h0000;
                end else if (ifc.wb_en && ifc.wb_base == 4'(r)) begin
                    rf_q[r] <= ifc.wb_y; // [RULE21]
                end else if (ifc.wb_en && ifc.wb_base + 4'h1 == 4'(r)) begin
                    rf_q[r] <= ifc.wb_x;
                end else if (ifc.wb_en && ifc.wb_base + 4'h2 == 4'(r)) begin
                    rf_q[r] <= ifc.wb_w;
                end else if (i_reg_we && i_reg_idx == 4'(r)) begin
                    rf_q[r] <= i_reg_wdata;
                end
            end
        end
    endgenerate

    // read port and completion pulse
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            rdata_q <= 16'h0000;
            done_q <= 1'b0;
        end else begin
            done_q <= ifc.wb_en;
            if (i_reg_re) begin
                rdata_q <= rf_q[i_reg_idx];
            end
        end
    end

    assign ifc.issue = issue_q;
    assign ifc.opcode = opcode_q;
    assign ifc.rr_form = 1'b1;
    assign ifc.base = base_q;
    assign ifc.func = func_q;
    assign ifc.op_y = y_q;
    assign ifc.op_x = x_q;
    assign ifc.op_w = w_q;
    assign o_stall = pend_q; // [RULE21]
    assign o_done = done_q;
    assign o_refused = refused_q;
    assign o_range_warn = warn_q;
    assign o_reg_rdata = rdata_q;
endmodule
`default_nettype wire

// ==== tb/thv_link_asserts.sv ====
// concurrent checks on the decoder-to-unit link of the vector/rotate unit
`timescale 1ns/1ps
`default_nettype none
module thv_link_asserts (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic issue,
    input wire logic [5:0] opcode,
    input wire logic rr_form,
    input wire logic [3:0] base,
    input wire logic [2:0] func,
    input wire thv_pkg::thv_word_t op_y,
    input wire thv_pkg::thv_word_t op_x,
    input wire logic busy,
    input wire logic wb_en,
    input wire logic [3:0] wb_base,
    input wire thv_pkg::thv_word_t wb_y,
    input wire thv_pkg::thv_word_t wb_w
);
    logic launch;
    logic [2:0] fn_q;
    logic [3:0] base_q;
    logic signed [15:0] y_q;
    logic signed [15:0] x_q;

    // request taken by an idle unit
    assign launch = issue && !busy;

    // function and operands kept from launch for write-back checks
    always_ff @(posedge i_mclk) begin
        if (launch) begin
            fn_q <= func;
            base_q <= base;
            y_q <= op_y;
            x_q <= op_x;
        end
    end

    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    // ****************
    // assertions
    // ****************
    a_issue_legal: assert property (issue |-> opcode == 6'h1f && rr_form)
        else $error("issue with wrong opcode or form");
    a_trig_latency: assert property (launch && !func[2] |-> ##19 wb_en)
        else $error("trig write-back not 19 cycles after launch");
    a_hyp_latency: assert property (launch && func[2] |-> ##20 wb_en)
        else $error("hyperbolic write-back not 20 cycles after launch");
    a_stall_span: assert property (launch && !func[2] |=>
        busy[*8] ##1 busy[*8] ##1 busy[*2] ##1 !busy)
        else $error("busy span wrong for trig operation");
    a_wb_single: assert property (wb_en |=> !wb_en)
        else $error("write-back longer than one cycle");
    a_wb_base: assert property (wb_en |-> wb_base == base_q)
        else $error("write-back base differs from launch base");
    a_vec_clear_y: assert property (wb_en && !fn_q[0] |-> wb_y + 16'h0004 <= 16'h0008)
        else $error("vector result y not cleared");
    a_rot_clear_w: assert property (wb_en && fn_q[0] |-> wb_w + 16'h0004 <= 16'h0008)
        else $error("rotate result angle not cleared");
    a_half_turn: assert property (wb_en && fn_q[2:0] == 3'h0 && x_q < 0 && y_q == 0
        |-> wb_w == 16'h8000)
        else $error("half turn angle not encoded negative");
    a_hyp_sign: assert property (wb_en && fn_q[2] && !fn_q[0] && y_q != 0
        |-> wb_w[15] == (y_q < 0))
        else $error("hyperbolic vector angle sign wrong");

    c_trig_vec: cover property (wb_en && fn_q == 3'h0);
    c_hyp_rot: cover property (wb_en && fn_q == 3'h7);
    c_half_turn: cover property (wb_en && wb_w == 16'h8000);
endmodule
`default_nettype wire

// ==== tb/tb_trig_hyperbolic_vector_rotate_unit.sv ====
// self-checking bench driving the decoder end of the vector/rotate unit
`timescale 1ns/1ps
`default_nettype none
`include "thv_params.svh"
module tb_trig_hyperbolic_vector_rotate_unit;
    localparam int MAX_CYC = 3000;
    logic i_mclk, i_rst, i_issue, i_rr_form, i_reg_we, i_reg_re;
    logic [5:0] i_opcode;
    logic [3:0] i_base, i_reg_idx;
    logic [2:0] i_func;
    logic [15:0] i_reg_wdata, o_reg_rdata;
    logic o_stall, o_done, o_refused, o_range_warn;
    logic [15:0] ry, rx, rw;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    int n;
    real pi = 3.14159265358979;

    thv_if link ();
    thv_cordic_unit thv_cordic_unit_inst (.i_mclk(i_mclk), .i_rst(i_rst), .ifc(link));
    thv_decode_end thv_decode_end_inst (.i_mclk(i_mclk), .i_rst(i_rst), .ifc(link),
        .i_issue(i_issue), .i_opcode(i_opcode), .i_rr_form(i_rr_form), .i_base(i_base),
        .i_func(i_func), .o_stall(o_stall), .o_done(o_done), .o_refused(o_refused),
        .o_range_warn(o_range_warn), .i_reg_we(i_reg_we), .i_reg_idx(i_reg_idx),
        .i_reg_wdata(i_reg_wdata), .i_reg_re(i_reg_re), .o_reg_rdata(o_reg_rdata));
    thv_link_asserts thv_link_asserts_inst (.i_mclk(i_mclk), .i_rst(i_rst),
        .issue(link.issue), .opcode(link.opcode), .rr_form(link.rr_form),
        .base(link.base), .func(link.func), .op_y(link.op_y), .op_x(link.op_x),
        .busy(link.busy), .wb_en(link.wb_en), .wb_base(link.wb_base),
        .wb_y(link.wb_y), .wb_w(link.wb_w));

    // 25 MHz clock
    initial begin
        i_mclk = 1'b0;
        forever #20 i_mclk = ~i_mclk;
    end

    // hang guard
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == MAX_CYC) begin
            error_cnt++;
            finish_test();
        end
    end

    // ****************
    // tasks
    // ****************
    task automatic finish_test();
        if (error_cnt == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // signed word compare within a tolerance
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input int tol);
        int d;
        d = $signed(got) - $signed(exp);
        checks++;
        if ((^got === 1'bx) || d > tol || d < -tol) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [15:0] q(input real v);
        return 16'($rtoi(v < 0.0 ? v - 0.5 : v + 0.5));
    endfunction

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        i_reg_we <= 1'b1;
        i_reg_idx <= a;
        i_reg_wdata <= d;
        @(posedge i_mclk);
        i_reg_we <= 1'b0;
        @(posedge i_mclk);
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        i_reg_re <= 1'b1;
        i_reg_idx <= a;
        @(posedge i_mclk);
        i_reg_re <= 1'b0;
        @(posedge i_mclk);
        d = o_reg_rdata;
    endtask

    task automatic go(input logic [5:0] op, input logic rr, input logic [3:0] b,
                      input logic [2:0] f);
        i_issue <= 1'b1;
        i_opcode <= op;
        i_rr_form <= rr;
        i_base <= b;
        i_func <= f;
        @(posedge i_mclk);
        i_issue <= 1'b0;
    endtask

    task automatic wait_done(output int cnt);
        cnt = 0;
        while (o_done !== 1'b1 && cnt < 40) begin
            @(posedge i_mclk);
            cnt++;
        end
    endtask

    // one operation against a real-valued reference of the function table
    task automatic run(input logic [3:0] b, input logic [2:0] f, input real y, x, w);
        real g, s, ey, ex, ew;
        int k;
        g = f[1] ? 1.0 : (f[2] ? 16384.0 / `THV_K_HYP : 32768.0 / `THV_K_TRIG);
        s = f[2] ? 16384.0 : 32768.0 / pi;
        ex = f[2] ? (f[0] ? x * $cosh(w) + y * $sinh(w) : $sqrt(x * x - y * y))
                  : (f[0] ? x * $cos(w) - y * $sin(w) : $sqrt(x * x + y * y));
        ey = !f[0] ? 0.0 : f[2] ? x * $sinh(w) + y * $cosh(w) : y * $cos(w) + x * $sin(w);
        ew = f[0] ? 0.0 : f[2] ? $atanh(y / x) : $atan2(y, x);
        wr(b, q(y * 32768.0));
        wr(b + 4'h1, q(x * 32768.0));
        wr(b + 4'h2, q(w * s));
        go(`THV_OPCODE, 1'b1, b, f);
        wait_done(k);
        chk(16'(k), f[2] ? 16'h0016 : 16'h0015, 0);
        chk({15'h0000, o_range_warn}, 16'h0000, 0);
        rd(b, ry);
        rd(b + 4'h1, rx);
        rd(b + 4'h2, rw);
        chk(ry, q(ey * g * 32768.0), 8);
        chk(rx, q(ex * g * 32768.0), 8);
        chk(rw, q(ew * s), 8);
    endtask

    // ****************
    // main sequence
    // ****************
    initial begin
        i_rst = 1'b1;
        i_issue = 1'b0;
        i_opcode = 6'h00;
        i_rr_form = 1'b0;
        i_base = 4'h0;
        i_func = 3'h0;
        i_reg_we = 1'b0;
        i_reg_re = 1'b0;
        i_reg_idx = 4'h0;
        i_reg_wdata = 16'h0000;
        repeat (6) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(posedge i_mclk);
        rd(4'h3, ry);
        chk(ry, 16'h0000, 0);
        // second request while stalled must not reach registers 9..11
        wr(4'hb, 16'h1234);
        go(`THV_OPCODE, 1'b1, 4'h2, 3'h0);
        repeat (3) @(posedge i_mclk);
        go(`THV_OPCODE, 1'b1, 4'h9, 3'h5);
        wait_done(n);
        rd(4'hb, ry);
        chk(ry, 16'h1234, 0);
        // wrong opcode, then wrong form
        for (int k = 0; k < 2; k++) begin
            go(k == 0 ? 6'h1e : `THV_OPCODE, k == 0, 4'h0, 3'h0);
            @(negedge i_mclk);
            chk({15'h0000, o_refused}, 16'h0001, 0);
            chk({15'h0000, o_stall}, 16'h0000, 0);
            @(posedge i_mclk);
        end
        // hyperbolic vector on zero registers: |y| >= |x| raises the warning
        go(`THV_OPCODE, 1'b1, 4'h0, 3'h4);
        wait_done(n);
        chk({15'h0000, o_range_warn}, 16'h0001, 0);
        run(4'h0, 3'h0, 0.3, 0.4, 0.0);
        run(4'he, 3'h2, -0.3, 0.4, 0.0);
        run(4'h3, 3'h0, 0.0, -0.4, 0.0);
        run(4'h4, 3'h1, 0.0, 0.3, pi / 6.0);
        run(4'h5, 3'h3, 0.2, 0.3, -2.0 * pi / 3.0);
        run(4'h6, 3'h4, 0.125, 0.25, 0.0);
        run(4'h7, 3'h6, -0.1, 0.2, 0.0);
        run(4'h8, 3'h5, 0.1, 0.2, 0.3);
        run(4'h9, 3'h7, 0.1, 0.2, -0.3);
        run(4'h9, 3'h7, $signed(ry) / 32768.0, $signed(rx) / 32768.0, 0.3);
        chk(ry, q(0.1 * 32768.0), 8);
        chk(rx, q(0.2 * 32768.0), 8);
        finish_test();
    end
endmodule
`default_nettype wire
